// >>> core/uvf_defs.svh
// constants of the output under-voltage fault supervisor
`ifndef UVF_DEFS_SVH
`define UVF_DEFS_SVH

// ************************************************************
// command codes of the two registers
// ************************************************************
`define UVF_CMD_UV_THRESHOLD 8'h44
`define UVF_CMD_UV_ACTION 8'h45

// ************************************************************
// action byte field layout
// ************************************************************
`define UVF_RESP_HI 7
`define UVF_RESP_LO 6
`define UVF_RETRY_HI 5
`define UVF_RETRY_LO 3
`define UVF_DELAY_HI 2
`define UVF_DELAY_LO 0
`define UVF_RETRY_NONE 3'h0
`define UVF_RETRY_FOREVER 3'h7

// ************************************************************
// reset values
// ************************************************************
`define UVF_ACTION_RESET 8'h80
`define UVF_THRESHOLD_RESET 16'h0000
`define UVF_STRAP_BASE 16'h0400
`define UVF_STRAP_STEP 16'h0100
`define UVF_ATTEMPT_RESET 3'h0
`define UVF_COUNT_ZERO 24'h000000

// ************************************************************
// timing: units in tenths of a millisecond, clock in kHz
// ************************************************************
`define UVF_CLK_KHZ 100000
`define UVF_RIDE_UNIT_MS_X10 100
`define UVF_RETRY_UNIT_MS_X10 82
`define UVF_KHZ_PER_TENTH_MS 10

`endif

// >>> core/uvf_pkg.sv
// types of the output under-voltage fault supervisor
package uvf_pkg;

	// supervisor states, one-hot
	typedef enum logic [5:0] {
		UVF_ST_OFF = 6'h01,
		UVF_ST_RUN = 6'h02,
		UVF_ST_RIDE = 6'h04,
		UVF_ST_WAIT = 6'h08,
		UVF_ST_HOLD = 6'h10,
		UVF_ST_LATCH = 6'h20
	} uvf_state_type;

	// response field codes
	typedef enum logic [1:0] {
		UVF_RESP_IGNORE = 2'h0,
		UVF_RESP_RIDE = 2'h1,
		UVF_RESP_RETRY = 2'h2,
		UVF_RESP_HOLD = 2'h3
	} uvf_resp_type;

endpackage

// >>> core/uvf_unit_timer.sv
// delay timer counting whole ride-through or retry units
`timescale 1ns/1ps
`include "uvf_defs.svh"

module uvf_unit_timer #(
	parameter int RIDE_CYC = 1000000,
	parameter int RETRY_CYC = 820000,
	parameter int CNT_W = 24
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic use_retry,
	input wire logic abort,
	input wire logic [2:0] units,
	output logic done,
	output logic busy
);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] unit_c;
	logic busy_q;
	logic done_q;

	// unit length picked by use
	assign unit_c = use_retry ? CNT_W'(RETRY_CYC) : CNT_W'(RIDE_CYC);

	// down counter loaded with units times unit length
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_q <= CNT_W'(`UVF_COUNT_ZERO);
			busy_q <= 1'b0;
		end else if (abort) begin
			busy_q <= 1'b0;
		end else if (start) begin
			cnt_q <= CNT_W'(CNT_W'(units) * unit_c); // R02 R03
			busy_q <= 1'b1;
		end else if (busy_q) begin
			if (cnt_q == CNT_W'(`UVF_COUNT_ZERO)) begin
				busy_q <= 1'b0;
			end else begin
				cnt_q <= cnt_q - CNT_W'(1);
			end
		end
	end

	// one-cycle expiry pulse
	always_ff @(posedge clk) begin
		if (!resetn) begin
			done_q <= 1'b0;
		end else begin
			done_q <= busy_q && !abort && !start && cnt_q == CNT_W'(`UVF_COUNT_ZERO);
		end
	end

	assign done = done_q;
	assign busy = busy_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	unit_load_a: assert property (start && !abort |=> busy_q && cnt_q == CNT_W'($past(units)) * $past(unit_c)) // R03
		else $error("timer load does not match units");
	ride_expiry_a: assert property (start && !abort && !use_retry && units == 3'h0 ##1 !abort && !start |=> done_q) // R02
		else $error("zero delay did not expire at once");

endmodule

// >>> core/uvf_top.sv
// output under-voltage fault supervisor with its two command registers
// ************************************************************
// Functional notes
// R01 - retry field all ones restarts without limit until off, bias loss or shutdown
// R02 - delay field sets ride-through time in 10 ms units
// R03 - delay field sets time between restart attempts in 8.2 ms units
// R04 - output compared with threshold; same threshold drops power good
// R05 - threshold takes strap-selected default at power-up
// R06 - threshold is a 16-bit word at 0x44, action a byte at 0x45
// R07 - every response code drives alert low and sets the fault status bit
// R08 - code 00 keeps regulating, only flags the fault
// R09 - code 01 rides through the delay, then follows retry setting
// R10 - code 10 disables at once, then follows retry setting
// R11 - code 11 holds output off while fault present, then resumes
// R12 - retry zero means no restart; off until fault cleared
// R13 - retry one to six allows that many restarts, then off until cleared
// R14 - attempt counter resets on enable command or fault clear
// ************************************************************
`timescale 1ns/1ps
`include "uvf_defs.svh"

module uvf_top #(
	parameter int RIDE_CYC = `UVF_RIDE_UNIT_MS_X10 * (`UVF_CLK_KHZ / `UVF_KHZ_PER_TENTH_MS),
	parameter int RETRY_CYC = `UVF_RETRY_UNIT_MS_X10 * (`UVF_CLK_KHZ / `UVF_KHZ_PER_TENTH_MS)
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RESETN,
	// command port from the bus interface
	input wire logic CMD_VALID,
	input wire logic CMD_WRITE,
	input wire logic [7:0] CMD_CODE,
	input wire logic [15:0] CMD_WDATA,
	output logic [15:0] CMD_RDATA,
	output logic CMD_ACK,
	output logic CMD_NACK,
	input wire logic FAULT_CLEAR,
	// power stage and monitoring
	input wire logic [15:0] VOUT_LEVEL,
	input wire logic [2:0] VOLTAGE_PIN_STRAP,
	input wire logic OUTPUT_ON_CMD,
	input wire logic BIAS_OK,
	input wire logic OTHER_SHUTDOWN,
	output logic OUTPUT_ENABLE,
	output logic OUTPUT_GOOD_FLAG,
	// alert line, open drain, active low, and the fault status bit
	input wire logic ALERT_LINE_N_I,
	output logic ALERT_LINE_N_O,
	output logic ALERT_LINE_N_OE,
	output logic STATUS_UV_FAULT
);

	// ************************************************************
	// registers and state
	// ************************************************************
	logic [15:0] threshold_q;
	logic [7:0] action_q;
	logic strap_done_q;
	uvf_pkg::uvf_state_type state_q, state_d;
	logic [2:0] attempts_q, attempts_d;
	logic status_q;
	logic out_en_q;
	logic pg_q;
	logic alert_oe_q;
	logic alert_seen_q;
	logic [15:0] rdata_q;
	logic ack_q;
	logic nack_q;
	logic uv;
	logic enabled;
	logic regulating;
	logic tmr_start, tmr_retry, tmr_abort, tmr_done;
	uvf_pkg::uvf_resp_type resp;
	logic [2:0] retry_set;
	logic [2:0] delay_set;

	// strap decode into factory threshold
	function automatic logic [15:0] strap_default(input logic [2:0] strap);
		strap_default = 16'(`UVF_STRAP_BASE + 16'(strap) * `UVF_STRAP_STEP);
	endfunction

	// true when a further restart is not allowed
	function automatic logic retries_spent(input logic [2:0] setting, input logic [2:0] used);
		retries_spent = setting == `UVF_RETRY_NONE || (setting != `UVF_RETRY_FOREVER && used >= setting);
	endfunction

	// field views of the action byte
	assign resp = uvf_pkg::uvf_resp_type'(action_q[`UVF_RESP_HI:`UVF_RESP_LO]);
	assign retry_set = action_q[`UVF_RETRY_HI:`UVF_RETRY_LO];
	assign delay_set = action_q[`UVF_DELAY_HI:`UVF_DELAY_LO];

	// comparator and run conditions
	assign uv = VOUT_LEVEL < threshold_q; // R04
	assign enabled = OUTPUT_ON_CMD && BIAS_OK && !OTHER_SHUTDOWN; // R01
	assign regulating = state_q == uvf_pkg::UVF_ST_RUN || state_q == uvf_pkg::UVF_ST_RIDE;

	// ************************************************************
	// command registers
	// ************************************************************

	// threshold: zero in reset, strap default on first clock after
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			threshold_q <= `UVF_THRESHOLD_RESET;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			threshold_q <= strap_default(VOLTAGE_PIN_STRAP); // R05
			strap_done_q <= 1'b1;
		end else if (CMD_VALID && CMD_WRITE && CMD_CODE == `UVF_CMD_UV_THRESHOLD) begin
			threshold_q <= CMD_WDATA; // R06
		end
	end

	// action byte
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			action_q <= `UVF_ACTION_RESET;
		end else if (CMD_VALID && CMD_WRITE && CMD_CODE == `UVF_CMD_UV_ACTION) begin
			action_q <= CMD_WDATA[7:0]; // R06
		end
	end

	// read data and answer strobes
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			rdata_q <= 16'h0000;
			ack_q <= 1'b0;
			nack_q <= 1'b0;
		end else begin
			ack_q <= 1'b0;
			nack_q <= 1'b0;
			if (CMD_VALID) begin
				unique case (CMD_CODE)
					`UVF_CMD_UV_THRESHOLD: begin
						rdata_q <= threshold_q; // R06
						ack_q <= 1'b1;
					end
					`UVF_CMD_UV_ACTION: begin
						rdata_q <= {8'h00, action_q}; // R06
						ack_q <= 1'b1;
					end
					default: begin
						rdata_q <= 16'h0000;
						nack_q <= 1'b1;
					end
				endcase
			end
		end
	end

	// ************************************************************
	// fault response sequencer
	// ************************************************************

	// next state, timer requests and attempt count
	always_comb begin
		state_d = state_q;
		attempts_d = attempts_q;
		tmr_start = 1'b0;
		tmr_retry = 1'b0;
		tmr_abort = 1'b0;
		if (!enabled) begin
			state_d = uvf_pkg::UVF_ST_OFF;
			attempts_d = `UVF_ATTEMPT_RESET; // R14
			tmr_abort = 1'b1;
		end else begin
			unique case (state_q)
				uvf_pkg::UVF_ST_OFF: begin
					state_d = uvf_pkg::UVF_ST_RUN;
				end
				uvf_pkg::UVF_ST_RUN: begin
					if (uv) begin
						unique case (resp)
							uvf_pkg::UVF_RESP_IGNORE: state_d = uvf_pkg::UVF_ST_RUN; // R08
							uvf_pkg::UVF_RESP_RIDE: begin
								state_d = uvf_pkg::UVF_ST_RIDE; // R09
								tmr_start = 1'b1; // R02
							end
							uvf_pkg::UVF_RESP_RETRY: begin
								tmr_retry = 1'b1; // R10
							end
							uvf_pkg::UVF_RESP_HOLD: state_d = uvf_pkg::UVF_ST_HOLD; // R11
						endcase
					end
				end
				uvf_pkg::UVF_ST_RIDE: begin
					if (!uv) begin
						state_d = uvf_pkg::UVF_ST_RUN;
						tmr_abort = 1'b1;
					end else if (tmr_done) begin
						tmr_retry = 1'b1; // R09
					end
				end
				uvf_pkg::UVF_ST_WAIT: begin
					if (tmr_done) begin
						state_d = uvf_pkg::UVF_ST_RUN;
					end
				end
				uvf_pkg::UVF_ST_HOLD: begin
					if (!uv) begin
						state_d = uvf_pkg::UVF_ST_RUN; // R11
					end
				end
				uvf_pkg::UVF_ST_LATCH: begin
					if (FAULT_CLEAR) begin
						state_d = uvf_pkg::UVF_ST_RUN;
					end
				end
				default: state_d = uvf_pkg::UVF_ST_OFF;
			endcase
			// disable and decide on a restart
			if (tmr_retry) begin
				if (retries_spent(retry_set, attempts_q)) begin
					state_d = uvf_pkg::UVF_ST_LATCH; // R12 R13
				end else begin
					state_d = uvf_pkg::UVF_ST_WAIT; // R01
					tmr_start = 1'b1; // R03
					if (retry_set != `UVF_RETRY_FOREVER) begin
						attempts_d = attempts_q + 3'h1; // R13
					end
				end
			end
			if (FAULT_CLEAR) begin
				attempts_d = `UVF_ATTEMPT_RESET; // R14
			end
		end
	end

	// sequencer state
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			state_q <= uvf_pkg::UVF_ST_OFF;
			attempts_q <= `UVF_ATTEMPT_RESET;
		end else begin
			state_q <= state_d;
			attempts_q <= attempts_d;
		end
	end

	// ride-through and retry delay timer
	uvf_unit_timer #(
		.RIDE_CYC(RIDE_CYC),
		.RETRY_CYC(RETRY_CYC),
		.CNT_W(24)
	) u_timer (
		.clk(SYS_CLK),
		.resetn(RESETN),
		.start(tmr_start),
		.use_retry(state_d == uvf_pkg::UVF_ST_WAIT),
		.abort(tmr_abort),
		.units(delay_set),
		.done(tmr_done),
		.busy()
	);

	// ************************************************************
	// outputs
	// ************************************************************

	// output enable and power good
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			out_en_q <= 1'b0;
			pg_q <= 1'b0;
		end else begin
			out_en_q <= state_d == uvf_pkg::UVF_ST_RUN || state_d == uvf_pkg::UVF_ST_RIDE;
			pg_q <= regulating && !uv; // R04
		end
	end

	// sticky fault bit, a new fault wins over the clear
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			status_q <= 1'b0;
		end else if (regulating && uv) begin
			status_q <= 1'b1; // R07
		end else if (FAULT_CLEAR) begin
			status_q <= 1'b0;
		end
	end

	// alert pull-down follows the fault bit
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			alert_oe_q <= 1'b0;
			alert_seen_q <= 1'b0;
		end else begin
			alert_oe_q <= status_q || (regulating && uv); // R07
			alert_seen_q <= !ALERT_LINE_N_I;
		end
	end

	assign OUTPUT_ENABLE = out_en_q;
	assign OUTPUT_GOOD_FLAG = pg_q;
	assign ALERT_LINE_N_O = 1'b0;
	assign ALERT_LINE_N_OE = alert_oe_q;
	assign STATUS_UV_FAULT = status_q;
	assign CMD_RDATA = rdata_q;
	assign CMD_ACK = ack_q;
	assign CMD_NACK = nack_q;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);

	fault_flagged_a: assert property (regulating && uv |=> status_q ##1 ALERT_LINE_N_OE) // R07
		else $error("fault not flagged on status and alert");
	ignore_keeps_on_a: assert property (state_q == uvf_pkg::UVF_ST_RUN && enabled && resp == uvf_pkg::UVF_RESP_IGNORE
		|=> state_q == uvf_pkg::UVF_ST_RUN) // R08
		else $error("ignore code left regulation");
	retry_disables_a: assert property (state_q == uvf_pkg::UVF_ST_RUN && enabled && uv
		&& resp == uvf_pkg::UVF_RESP_RETRY |=> !OUTPUT_ENABLE) // R10
		else $error("output not disabled at once");
	ride_keeps_on_a: assert property (state_q == uvf_pkg::UVF_ST_RUN && enabled && uv
		&& resp == uvf_pkg::UVF_RESP_RIDE |=> OUTPUT_ENABLE && state_q == uvf_pkg::UVF_ST_RIDE) // R09
		else $error("ride-through did not keep output on");
	hold_resumes_a: assert property (state_q == uvf_pkg::UVF_ST_HOLD && enabled && !uv
		|=> state_q == uvf_pkg::UVF_ST_RUN && OUTPUT_ENABLE) // R11
		else $error("hold did not resume");
	no_retry_latch_a: assert property (tmr_retry && retry_set == `UVF_RETRY_NONE
		|=> state_q == uvf_pkg::UVF_ST_LATCH) // R12
		else $error("zero retry setting restarted");
	forever_retry_a: assert property (tmr_retry && retry_set == `UVF_RETRY_FOREVER
		|=> state_q == uvf_pkg::UVF_ST_WAIT) // R01
		else $error("continuous retry stopped");
	attempt_bound_a: assert property (tmr_retry && retry_set != `UVF_RETRY_FOREVER && attempts_q >= retry_set
		&& !FAULT_CLEAR |=> state_q == uvf_pkg::UVF_ST_LATCH && $stable(attempts_q)) // R13
		else $error("retries exceeded setting");
	pg_drop_a: assert property (uv |=> !OUTPUT_GOOD_FLAG) // R04
		else $error("power good held below threshold");
	strap_load_a: assert property ($rose(strap_done_q) |-> threshold_q == strap_default($past(VOLTAGE_PIN_STRAP))) // R05
		else $error("threshold not loaded from strap");
	attempts_clear_a: assert property (!enabled || FAULT_CLEAR |=> attempts_q == `UVF_ATTEMPT_RESET) // R14
		else $error("attempt counter not cleared");
	action_read_a: assert property (CMD_VALID && !CMD_WRITE && CMD_CODE == `UVF_CMD_UV_ACTION
		|=> CMD_ACK && CMD_RDATA == {8'h00, action_q}) // R06
		else $error("action byte read wrong");

	ride_cover_c: cover property (state_q == uvf_pkg::UVF_ST_RIDE ##1 state_q == uvf_pkg::UVF_ST_WAIT);
	latch_cover_c: cover property (state_q == uvf_pkg::UVF_ST_LATCH ##1 state_q == uvf_pkg::UVF_ST_RUN);
	hold_cover_c: cover property (state_q == uvf_pkg::UVF_ST_HOLD ##1 state_q == uvf_pkg::UVF_ST_RUN);
	restart_cover_c: cover property (state_q == uvf_pkg::UVF_ST_WAIT && tmr_done && alert_seen_q);

endmodule

// >>> tb/uvf_host_model.sv
// host-side command master model driving the supervisor command port
`timescale 1ns/1ps

module uvf_host_model (
	// clock
	input wire logic clk,
	// command port toward the supervisor
	output logic cmd_valid,
	output logic cmd_write,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata
);

	// ************************************************************
	// idle bus at time zero
	// ************************************************************
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end

	// ************************************************************
	// one request, after a random idle gap (prompt or slow host)
	// ************************************************************
	task automatic issue(input logic wr, input logic [7:0] code, input logic [15:0] data);
		int gap;
		gap = $urandom_range(2, 0);
		repeat (gap + 1) @(posedge clk);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_code <= code;
		cmd_wdata <= data;
		@(posedge clk);
		// taken at this edge; released lines stop showing old values
		cmd_valid <= 1'b0;
		cmd_write <= ~wr;
		cmd_code <= ~code;
		cmd_wdata <= ~data;
	endtask

endmodule

// >>> tb/output_uv_fault_response_bench.sv
// self-checking bench for the output under-voltage fault supervisor
`timescale 1ns/1ps
`include "uvf_defs.svh"

module output_uv_fault_response_bench;

	// ************************************************************
	// signals
	// ************************************************************
	logic clk, rst_n, valid, wr, ack, nack, fclr, on_cmd, bias, other_sd;
	logic en, pg, al_i, al_o, al_oe, status;
	logic [7:0] code;
	logic [15:0] wdata, rdata, vout, thr, vhi, vlo;
	logic [2:0] strap;
	logic [17:0] exp_q[$];
	logic [17:0] e;
	int fail_count, num_checks, n, r;
	logic [7:0] budget_act[4] = '{8'h81, 8'h99, 8'hB1, 8'hB9};

	// open-drain alert wire with pull-up
	assign al_i = al_oe ? al_o : 1'b1;

	uvf_top #(.RIDE_CYC(20), .RETRY_CYC(16)) uvf_top_inst (
		.SYS_CLK(clk), .RESETN(rst_n), .CMD_VALID(valid), .CMD_WRITE(wr), .CMD_CODE(code),
		.CMD_WDATA(wdata), .CMD_RDATA(rdata), .CMD_ACK(ack), .CMD_NACK(nack), .FAULT_CLEAR(fclr),
		.VOUT_LEVEL(vout), .VOLTAGE_PIN_STRAP(strap), .OUTPUT_ON_CMD(on_cmd), .BIAS_OK(bias),
		.OTHER_SHUTDOWN(other_sd), .OUTPUT_ENABLE(en), .OUTPUT_GOOD_FLAG(pg), .ALERT_LINE_N_I(al_i),
		.ALERT_LINE_N_O(al_o), .ALERT_LINE_N_OE(al_oe), .STATUS_UV_FAULT(status));

	uvf_host_model uvf_host_model_inst (.clk(clk), .cmd_valid(valid), .cmd_write(wr), .cmd_code(code),
		.cmd_wdata(wdata));

	// ************************************************************
	// clock
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic report_and_stop();
		if (fail_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	// note the expected answer, then let the host issue the command
	task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d, input logic nk,
		input logic [15:0] exp_rd);
		exp_q.push_back({~w, nk, exp_rd});
		uvf_host_model_inst.issue(w, c, d);
	endtask

	// bounded wait for the enable to reach a level; n counts cycles
	task automatic wait_en(input logic v, input int lim);
		n = 0;
		while (en !== v) begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				check("enable wait", v, en);
				report_and_stop();
			end
		end
	endtask

	// count restarts (enable rising) over a fixed window
	task automatic count_rises(input int len);
		logic prev;
		r = 0;
		prev = en;
		repeat (len) begin
			@(negedge clk);
			if (prev === 1'b0 && en === 1'b1) r++;
			prev = en;
		end
	endtask

	// leave any fault state with the output healthy
	task automatic recover();
		@(posedge clk);
		other_sd <= 1'b0;
		vout <= vhi;
		fclr <= 1'b1;
		@(posedge clk);
		fclr <= 1'b0;
		@(negedge clk);
		wait_en(1'b1, 10);
	endtask

	// ************************************************************
	// answer watcher: oldest note against each ack or nack
	// ************************************************************
	always @(negedge clk) begin
		if (rst_n === 1'b1 && (ack === 1'b1 || nack === 1'b1)) begin
			if (exp_q.size() == 0) begin
				check("unrequested answer", 0, 1);
			end else begin
				e = exp_q.pop_front();
				check("nack", e[16], nack);
				check("ack", !e[16], ack);
				if (e[17]) check("read data", e[15:0], rdata);
			end
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		fail_count = 0;
		num_checks = 0;
		void'($urandom(28204));
		rst_n = 1'b0;
		fclr = 1'b0;
		on_cmd = 1'b1;
		bias = 1'b1;
		other_sd = 1'b0;
		strap = 3'($urandom_range(7, 0));
		thr = 16'h2000 + 16'($urandom_range(4095, 0));
		vhi = thr + 16'h0100;
		vlo = thr - 16'h0001;
		vout = 16'hFFFF;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		// reset values, registers, unmapped code
		cmd(0, `UVF_CMD_UV_THRESHOLD, 16'h0000, 0, 16'h0400 + 16'(strap) * 16'h0100);
		cmd(0, `UVF_CMD_UV_ACTION, 16'h0000, 0, 16'h0080);
		cmd(1, `UVF_CMD_UV_THRESHOLD, thr, 0, 16'h0000);
		cmd(0, `UVF_CMD_UV_THRESHOLD, 16'h0000, 0, thr);
		cmd(0, 8'h46, 16'h0000, 1, 16'h0000);
		// code 00: threshold edge, flagging only
		cmd(1, `UVF_CMD_UV_ACTION, 16'h0000, 0, 16'h0000);
		@(posedge clk);
		vout <= thr;
		repeat (4) @(negedge clk);
		check("good at threshold", 1, pg);
		check("status at threshold", 0, status);
		@(posedge clk);
		vout <= vlo;
		repeat (3) @(negedge clk);
		check("good below threshold", 0, pg);
		check("status", 1, status);
		check("alert wire", 0, al_i);
		check("enable kept", 1, en);
		recover();
		check("status cleared", 0, status);
		// code 01: ride through 2 units, then retry 0 latches off
		cmd(1, `UVF_CMD_UV_ACTION, 16'h0042, 0, 16'h0000);
		@(posedge clk);
		vout <= vlo;
		wait_en(1'b0, 100);
		check("ride time", 1, n >= 40 && n <= 46);
		count_rises(60);
		check("ride restarts", 0, r);
		check("ride alert", 0, al_i);
		recover();
		// zero delay ride-through expires at once, then latches off
		cmd(1, `UVF_CMD_UV_ACTION, 16'h0040, 0, 16'h0000);
		@(posedge clk);
		vout <= vlo;
		wait_en(1'b0, 10);
		check("zero ride time", 1, n >= 3 && n <= 6);
		recover();
		// code 10, retry 1, delay 3: retry spacing
		cmd(1, `UVF_CMD_UV_ACTION, 16'h008B, 0, 16'h0000);
		@(posedge clk);
		vout <= vlo;
		wait_en(1'b0, 5);
		check("disable latency", 1, n <= 2);
		wait_en(1'b1, 100);
		check("retry spacing", 1, n >= 48 && n <= 52);
		count_rises(100);
		check("retry once", 0, r);
		// retry budgets 0, 3, 6 and continuous, each from a fresh budget
		for (int i = 0; i < 4; i++) begin
			recover();
			cmd(1, `UVF_CMD_UV_ACTION, {8'h00, budget_act[i]}, 0, 16'h0000);
			@(posedge clk);
			vout <= vlo;
			count_rises(250);
			if (i < 3) check("restarts", (i == 0) ? 0 : (i == 1) ? 3 : 6, r);
			if (i == 3) check("continuous", 1, r >= 8);
		end
		// another fault ends continuous retry
		@(posedge clk);
		other_sd <= 1'b1;
		count_rises(60);
		check("stopped retry", 0, r);
		check("stopped enable", 0, en);
		recover();
		// code 11: held off while low, resumes when level returns
		cmd(1, `UVF_CMD_UV_ACTION, 16'h00C0, 0, 16'h0000);
		@(posedge clk);
		vout <= vlo;
		wait_en(1'b0, 5);
		count_rises(40);
		check("hold restarts", 0, r);
		@(posedge clk);
		vout <= vhi;
		wait_en(1'b1, 4);
		check("hold resume", 1, en);
		repeat (4) @(posedge clk);
		check("notes left", 0, exp_q.size());
		report_and_stop();
	end

endmodule
